// >>> hw/product_quotient_pkg.sv
// constants and types for the multiply and divide datapath
package product_quotient_pkg;

  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int DEST_W = 5;
  localparam int PROD_W = 64;

  localparam logic [31:0] ACC_RESET = 32'h0000_0000;

  // reissue interval of a division per dividend class; latency is one less
  localparam logic [5:0] DIV_REPEAT_8  = 6'h0b;
  localparam logic [5:0] DIV_REPEAT_16 = 6'h12;
  localparam logic [5:0] DIV_REPEAT_24 = 6'h19;
  localparam logic [5:0] DIV_REPEAT_32 = 6'h20;

  // iterations left after skipping 23, 15 and 7
  localparam logic [5:0] DIV_BITS_8  = 6'h09;
  localparam logic [5:0] DIV_BITS_16 = 6'h11;
  localparam logic [5:0] DIV_BITS_24 = 6'h19;
  localparam logic [5:0] DIV_BITS_32 = 6'h20;
  localparam logic [5:0] DIV_FULL    = 6'h20;

  typedef enum logic [3:0] {
    idle_op            = 4'h0,
    product_to_acc_op  = 4'h1,
    acc_add_product_op = 4'h2,
    acc_sub_product_op = 4'h3,
    product_to_gpr_op  = 4'h4,
    quotient_op        = 4'h5,
    read_acc_upper_op  = 4'h6,
    read_acc_bottom_op = 4'h7
  } op_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_pass2  = 3'b010,
    st_divide = 3'b100
  } state_t;

  typedef struct packed {
    logic              valid;
    op_t               op;
    logic              is_unsigned;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] src_a;
    logic [DATA_W-1:0] src_b;
  } issue_t;

  typedef struct packed {
    logic              valid;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } result_t;

endpackage : product_quotient_pkg

// >>> hw/product_quotient_unit.sv
// multiply, multiply-accumulate and early-in divide datapath
`timescale 1ns/1ps
`default_nettype none
module product_quotient_unit (
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire product_quotient_pkg::issue_t  issue,
  output var  logic                          issue_stall,
  output var  product_quotient_pkg::result_t gpr_result,
  output var  logic [31:0]                   acc_upper_word,
  output var  logic [31:0]                   acc_bottom_word
);
  import product_quotient_pkg::*;

  state_t state;
  state_t next_state;

  // issue decode
  wire logic take;
  wire logic take_mul;
  wire logic take_div;
  wire logic take_read;
  wire logic sgn;

  // the stall flop already refuses issues while busy, so the
  // pipe holding its request is all that is needed from it
  assign take      = issue.valid && !issue_stall;
  assign take_mul  = take && (issue.op == product_to_acc_op ||
                              issue.op == acc_add_product_op ||
                              issue.op == acc_sub_product_op ||
                              issue.op == product_to_gpr_op);
  assign take_div  = take && issue.op == quotient_op;
  assign take_read = take && (issue.op == read_acc_upper_op ||
                              issue.op == read_acc_bottom_op);
  assign sgn       = !issue.is_unsigned;

  // width class of source_b_operand decides the pass count alone
  wire logic b_narrow;
  assign b_narrow = issue.is_unsigned ? (issue.src_b[31:16] == 16'h0000) :
                    (issue.src_b[31:15] == {17{issue.src_b[31]}});

  // second pass holding state
  op_t               pend_op;
  logic [DEST_W-1:0] pend_dest;
  logic [32:0]       pend_a;
  logic [16:0]       pend_bhi;
  logic [63:0]       pend_part;

  // one shared 33x17 signed array; extension bits carry signedness
  wire logic signed [32:0] arr_a;
  wire logic signed [16:0] arr_b;
  wire logic signed [49:0] arr_p;
  wire logic        [63:0] arr_ext;
  wire logic        [32:0] a_ext;
  wire logic        [16:0] b_lo_ext;
  wire logic        [16:0] b_hi_ext;

  assign a_ext    = {sgn & issue.src_a[31], issue.src_a};
  assign b_lo_ext = {b_narrow & sgn & issue.src_b[15], issue.src_b[15:0]};
  assign b_hi_ext = {sgn & issue.src_b[31], issue.src_b[31:16]};
  assign arr_a    = (state == st_pass2) ? pend_a : a_ext;
  assign arr_b    = (state == st_pass2) ? pend_bhi : b_lo_ext;
  assign arr_p    = arr_a * arr_b;
  assign arr_ext  = {{14{arr_p[49]}}, arr_p};

  // completed product, from the first pass or after the second
  wire logic        done;
  wire op_t         done_op;
  wire logic [63:0] done_prod;
  wire logic [4:0]  done_dest;

  assign done      = (state == st_pass2) || (take_mul && b_narrow);
  assign done_op   = (state == st_pass2) ? pend_op : issue.op;
  assign done_dest = (state == st_pass2) ? pend_dest : issue.dest;
  assign done_prod = (state == st_pass2) ? pend_part + {arr_ext[47:0], 16'h0000} :
                     arr_ext;

  // accumulator update
  wire logic [63:0] acc_pair;
  wire logic [63:0] acc_next_mul;
  wire logic        acc_target;

  assign acc_pair     = {acc_upper_word, acc_bottom_word};
  assign acc_target   = done && done_op != product_to_gpr_op;
  assign acc_next_mul = (done_op == acc_add_product_op) ? acc_pair + done_prod :
                        (done_op == acc_sub_product_op) ? acc_pair - done_prod :
                        done_prod;

  // dividend class from its own sign extension
  wire logic        a_fill;
  wire logic [5:0]  cls_bits;
  wire logic [5:0]  cls_repeat;
  wire logic [31:0] abs_a;
  wire logic [31:0] abs_b;

  assign a_fill     = sgn & issue.src_a[31];
  assign cls_bits   = (issue.src_a[31:7] == {25{a_fill}})  ? DIV_BITS_8  :
                      (issue.src_a[31:15] == {17{a_fill}}) ? DIV_BITS_16 :
                      (issue.src_a[31:23] == {9{a_fill}})  ? DIV_BITS_24 :
                      DIV_BITS_32;
  assign cls_repeat = (cls_bits == DIV_BITS_8)  ? DIV_REPEAT_8  :
                      (cls_bits == DIV_BITS_16) ? DIV_REPEAT_16 :
                      (cls_bits == DIV_BITS_24) ? DIV_REPEAT_24 :
                      DIV_REPEAT_32;
  assign abs_a      = a_fill ? 32'h0 - issue.src_a : issue.src_a;
  assign abs_b      = (sgn & issue.src_b[31]) ? 32'h0 - issue.src_b : issue.src_b;

  // divider state
  logic [5:0]  div_cnt;
  logic [5:0]  div_bits;
  logic [31:0] div_q;
  logic [32:0] div_r;
  logic [31:0] div_d;
  logic        neg_q;
  logic        neg_r;

  // the issue edge is itself the first possible iteration, which is
  // what lets a full 32 bit divide fit in its reissue interval
  wire logic [5:0]  edges_left;
  wire logic [5:0]  bits_cur;
  wire logic [31:0] st_q;
  wire logic [32:0] st_r;
  wire logic [31:0] st_d;
  wire logic        iterate;

  assign edges_left = take_div ? cls_repeat : div_cnt;
  assign bits_cur   = take_div ? cls_bits : div_bits;
  assign st_q       = take_div ? abs_a << (DIV_FULL - cls_bits) : div_q;
  assign st_r       = take_div ? 33'h0 : div_r;
  assign st_d       = take_div ? abs_b : div_d;
  assign iterate    = (take_div || state == st_divide) && edges_left <= bits_cur;

  // one restoring step: one quotient bit per clock
  wire logic [32:0] r_sh;
  wire logic [32:0] r_diff;
  wire logic        q_bit;
  wire logic [31:0] q_new;
  wire logic [32:0] r_new;

  assign r_sh   = {st_r[31:0], st_q[31]};
  assign r_diff = r_sh - {1'b0, st_d};
  assign q_bit  = !r_diff[32];
  assign q_new  = iterate ? {st_q[30:0], q_bit} : st_q;
  assign r_new  = iterate ? (q_bit ? r_diff : r_sh) : st_r;

  wire logic        div_finish;
  wire logic [31:0] q_fin;
  wire logic [31:0] r_fin;

  assign div_finish = (state == st_divide) && div_cnt == 6'h01;
  assign q_fin      = neg_q ? 32'h0 - q_new : q_new;
  assign r_fin      = neg_r ? 32'h0 - r_new[31:0] : r_new[31:0];

  // sequencing; no input from the pipe can hold a pass or a division back
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (take_mul && !b_narrow) begin
          next_state = st_pass2;
        end else if (take_div) begin
          next_state = st_divide;
        end
      end
      st_pass2: begin
        next_state = st_idle;
      end
      st_divide: begin
        if (div_finish) begin
          next_state = st_idle;
        end
      end
    endcase
  end

  // read and targeted results share two register stages
  wire logic        stage_load;
  wire logic [31:0] stage_data;
  wire logic [4:0]  stage_dest;

  assign stage_load = (done && done_op == product_to_gpr_op) || take_read;
  assign stage_data = take_read ?
                      (issue.op == read_acc_upper_op ? acc_upper_word : acc_bottom_word) :
                      done_prod[31:0];
  assign stage_dest = take_read ? issue.dest : done_dest;

  result_t stage;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state       <= st_idle;
      issue_stall <= 1'b0;
    end else begin
      state       <= next_state;
      issue_stall <= next_state != st_idle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage      <= '0;
      gpr_result <= '0;
    end else begin
      stage      <= '{valid: stage_load, dest: stage_dest, data: stage_data};
      gpr_result <= stage;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_upper_word  <= ACC_RESET;
      acc_bottom_word <= ACC_RESET;
    end else if (div_finish) begin
      acc_upper_word  <= r_fin;
      acc_bottom_word <= q_fin;
    end else if (acc_target) begin
      acc_upper_word  <= acc_next_mul[63:32];
      acc_bottom_word <= acc_next_mul[31:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_op   <= idle_op;
      pend_dest <= '0;
      pend_a    <= '0;
      pend_bhi  <= '0;
      pend_part <= '0;
    end else if (take_mul && !b_narrow) begin
      pend_op   <= issue.op;
      pend_dest <= issue.dest;
      pend_a    <= a_ext;
      pend_bhi  <= b_hi_ext;
      pend_part <= arr_ext;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_cnt  <= 6'h00;
      div_bits <= 6'h00;
      div_q    <= '0;
      div_r    <= '0;
      div_d    <= '0;
      neg_q    <= 1'b0;
      neg_r    <= 1'b0;
    end else if (take_div || state == st_divide) begin
      div_cnt  <= edges_left - 6'h01;
      div_bits <= bits_cur;
      div_q    <= q_new;
      div_r    <= r_new;
      div_d    <= st_d;
      if (take_div) begin
        neg_q <= sgn & (issue.src_a[31] ^ issue.src_b[31]);
        neg_r <= a_fill;
      end
    end
  end

endmodule : product_quotient_unit
`default_nettype wire

// >>> sim/product_quotient_asserts.sv
// assertion checker for the multiply and divide datapath
`timescale 1ns/1ps
`default_nettype none
module product_quotient_asserts (
  input wire logic                          ref_clk,
  input wire logic                          srst,
  input wire product_quotient_pkg::issue_t  issue,
  input wire logic                          issue_stall,
  input wire product_quotient_pkg::result_t gpr_result,
  input wire logic [31:0]                   acc_upper_word,
  input wire logic [31:0]                   acc_bottom_word
);
  import product_quotient_pkg::*;
  logic [31:0] a, b, lo;
  logic        u, tk, mul, wide, s8, s16, s24, pend;
  logic [63:0] prod, acc;
  logic [5:0]  len, len_q, cnt;
  assign a = issue.src_a;
  assign b = issue.src_b;
  assign u = issue.is_unsigned;
  assign tk = issue.valid && !issue_stall;
  assign mul = issue.op inside {product_to_acc_op, acc_add_product_op, acc_sub_product_op,
                                product_to_gpr_op};
  assign wide = u ? |b[31:16] : !(&b[31:15] || ~|b[31:15]);
  // sign extension then unsigned multiply gives the signed product modulo 2^64
  assign prod = u ? {32'h0, a} * {32'h0, b} : {{32{a[31]}}, a} * {{32{b[31]}}, b};
  assign lo = prod[31:0];
  assign acc = {acc_upper_word, acc_bottom_word};
  assign s8 = u ? ~|a[31:7] : (&a[31:7] || ~|a[31:7]);
  assign s16 = u ? ~|a[31:15] : (&a[31:15] || ~|a[31:15]);
  assign s24 = u ? ~|a[31:23] : (&a[31:23] || ~|a[31:23]);
  assign len = s8 ? DIV_REPEAT_8 : s16 ? DIV_REPEAT_16 : s24 ? DIV_REPEAT_24 : DIV_REPEAT_32;
  // counts refused cycles of the running division
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend <= 1'b0;
      cnt <= 6'h00;
      len_q <= 6'h00;
    end else if (tk && issue.op == quotient_op) begin
      pend <= 1'b1;
      cnt <= 6'h00;
      len_q <= len;
    end else if (issue_stall) begin
      cnt <= cnt + 6'h01;
    end else begin
      pend <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_one_stall;
    issue_stall ##1 !issue_stall;
  endsequence
  a_wide_one_stall: assert property (tk && mul && wide |=> s_one_stall)
    else $error("wide product not refused for exactly one cycle");
  a_narrow_no_stall: assert property (tk && mul && !wide |=> !issue_stall)
    else $error("narrow product refused a following issue");
  a_gpr_narrow_out: assert property (tk && issue.op == product_to_gpr_op && !wide
    |-> ##2 gpr_result.valid && gpr_result.data == $past(lo, 2)
    && gpr_result.dest == $past(issue.dest, 2))
    else $error("narrow gpr product wrong");
  a_gpr_wide_out: assert property (tk && issue.op == product_to_gpr_op && wide
    |-> ##3 gpr_result.valid && gpr_result.data == $past(lo, 3)
    && gpr_result.dest == $past(issue.dest, 3))
    else $error("wide gpr product wrong");
  a_acc_load_now: assert property (tk && issue.op == product_to_acc_op && !wide
    |=> acc == $past(prod)) else $error("accumulator load wrong");
  a_acc_add_now: assert property (tk && issue.op == acc_add_product_op && !wide
    |=> acc == $past(acc) + $past(prod)) else $error("accumulate add wrong");
  a_acc_sub_now: assert property (tk && issue.op == acc_sub_product_op && !wide
    |=> acc == $past(acc) - $past(prod)) else $error("accumulate subtract wrong");
  a_div_stall_len: assert property (pend && !issue_stall |-> cnt == len_q - 6'h01)
    else $error("division refused for wrong number of cycles");
  a_read_upper_out: assert property (tk && issue.op == read_acc_upper_op |-> ##2
    gpr_result.valid && gpr_result.data == $past(acc_upper_word, 2)) else $error("read wrong");
endmodule : product_quotient_asserts
`default_nettype wire

// >>> sim/int_pipe_model.sv
// integer pipe model: presents operations and holds them while refused
`timescale 1ns/1ps
`default_nettype none
module int_pipe_model (
  input wire logic                          ref_clk,
  input wire logic                          srst,
  input wire product_quotient_pkg::issue_t  cmd,
  input wire logic                          issue_stall,
  output var product_quotient_pkg::issue_t  issue
);
  import product_quotient_pkg::*;
  // no width hint travels with an operation
  // a refused issue stays unchanged until taken
  // idle fields are scrambled so stale operands never look valid
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      issue <= '0;
    end else if (!issue.valid || !issue_stall) begin
      issue <= cmd.valid ? cmd : {1'b0, ~issue[$bits(issue_t)-2:0]};
    end
  end
endmodule : int_pipe_model
`default_nettype wire

// >>> sim/tb_product_quotient_unit.sv
// testbench for the multiply and divide datapath
`timescale 1ns/1ps
`default_nettype none
module tb_product_quotient_unit;
  import product_quotient_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  issue_t      cmd = '0;
  issue_t      issue;
  logic        issue_stall;
  result_t     gpr_result;
  logic [31:0] acc_upper_word, acc_bottom_word;
  logic [31:0] last_gpr = 32'h0;
  logic [4:0]  last_dest = 5'h00;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  product_quotient_unit i_product_quotient_unit (.ref_clk(ref_clk), .srst(srst),
    .issue(issue), .issue_stall(issue_stall), .gpr_result(gpr_result),
    .acc_upper_word(acc_upper_word), .acc_bottom_word(acc_bottom_word));
  int_pipe_model i_int_pipe_model (.ref_clk(ref_clk), .srst(srst), .cmd(cmd),
    .issue_stall(issue_stall), .issue(issue));
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // the ceiling is far above the few hundred cycles the scenarios need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (gpr_result.valid === 1'b1) last_gpr <= gpr_result.data;
    if (gpr_result.valid === 1'b1) last_dest <= gpr_result.dest;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  function automatic logic [63:0] prodf(input logic u, input logic [31:0] a, b);
    return u ? {32'h0, a} * {32'h0, b} : {{32{a[31]}}, a} * {{32{b[31]}}, b};
  endfunction : prodf
  function automatic logic [63:0] divf(input logic u, input logic [31:0] a, b);
    if (u) return {a % b, a / b};
    return {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
  endfunction : divf
  task automatic chk(input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // issue one operation, wait until taken, then until refusals end plus result time
  task automatic run(input op_t o, input logic u, input logic [31:0] a, b);
    @(posedge ref_clk) cmd <= '{1'b1, o, u, 5'h03, a, b};
    @(posedge ref_clk) cmd <= '0;
    repeat (40) begin
      #1;
      if (issue.valid === 1'b1 && issue_stall === 1'b0) break;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (issue_stall === 1'b0) break;
    end
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : run
  task automatic t_acc_ops;
    logic [63:0] e;
    run(product_to_acc_op, 1'b0, 32'hffff_fffd, 32'h7);
    e = prodf(1'b0, 32'hffff_fffd, 32'h7);
    chk({acc_upper_word, acc_bottom_word}, e);
    run(acc_add_product_op, 1'b0, 32'h1234_5678, 32'h0001_0000);
    e = e + prodf(1'b0, 32'h1234_5678, 32'h0001_0000);
    chk({acc_upper_word, acc_bottom_word}, e);
    run(acc_add_product_op, 1'b0, 32'h5, 32'hffff_fffe);
    e = e + prodf(1'b0, 32'h5, 32'hffff_fffe);
    chk({acc_upper_word, acc_bottom_word}, e);
    run(acc_sub_product_op, 1'b1, 32'hffff_0000, 32'h8000);
    e = e - prodf(1'b1, 32'hffff_0000, 32'h8000);
    chk({acc_upper_word, acc_bottom_word}, e);
    run(product_to_acc_op, 1'b1, 32'hffff_ffff, 32'hffff_ffff);
    chk({acc_upper_word, acc_bottom_word}, 64'hffff_fffe_0000_0001);
  endtask : t_acc_ops
  task automatic t_gpr;
    logic [63:0] e, keep;
    keep = {acc_upper_word, acc_bottom_word};
    run(product_to_gpr_op, 1'b0, 32'h8000_0001, 32'h0001_0003);
    e = prodf(1'b0, 32'h8000_0001, 32'h0001_0003);
    chk({32'h0, last_gpr}, {32'h0, e[31:0]});
    chk({59'h0, last_dest}, {59'h0, 5'h03});
    run(product_to_gpr_op, 1'b1, 32'hffff_ffff, 32'hffff);
    chk({32'h0, last_gpr}, 64'h0000_0000_ffff_0001);
    chk({acc_upper_word, acc_bottom_word}, keep);
  endtask : t_gpr
  task automatic t_div;
    logic [31:0] da[5] = '{32'hffff_ff9c, 32'h7530, 32'hffed_cbaa, 32'h7fff_ffff, 32'h8000_00ff};
    logic [31:0] db[5] = '{32'h7, 32'hffff_fff7, 32'h64, 32'h3, 32'h10};
    logic        du[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [63:0] e;
    for (int i = 0; i < 5; i++) begin
      run(quotient_op, du[i], da[i], db[i]);
      e = divf(du[i], da[i], db[i]);
      chk({acc_upper_word, acc_bottom_word}, e);
    end
    run(read_acc_upper_op, 1'b0, 32'h0, 32'h0);
    chk({32'h0, last_gpr}, {32'h0, e[63:32]});
    run(read_acc_bottom_op, 1'b0, 32'h0, 32'h0);
    chk({32'h0, last_gpr}, {32'h0, e[31:0]});
  endtask : t_div
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    t_acc_ops;
    t_gpr;
    t_div;
    report_and_stop;
  end
endmodule : tb_product_quotient_unit
bind product_quotient_unit product_quotient_asserts i_product_quotient_asserts (
  .ref_clk(ref_clk), .srst(srst), .issue(issue), .issue_stall(issue_stall),
  .gpr_result(gpr_result), .acc_upper_word(acc_upper_word), .acc_bottom_word(acc_bottom_word));
`default_nettype wire
